// [rtl/oipr_pkg.sv]
// oipr_pkg: register map, field positions, reset values and carriers for the
// option / interrupt control / program counter register bank.
// assumes an APB slave with 32-bit data, one register per aligned word.
package oipr_pkg;

   // =====================================================================
   // register map
   // printed offsets are not all multiples of four, so they are indices
   localparam logic [7:0]  IDX_INTCTL_B0 = 8'h0B;
   localparam logic [7:0]  IDX_INTCTL_B1 = 8'h8B;
   localparam logic [7:0]  IDX_OPTION    = 8'h81;
   localparam logic [7:0]  IDX_PC_LOW    = 8'h02;
   localparam logic [7:0]  IDX_PC_LATCH  = 8'h0A;
   localparam logic [7:0]  IDX_EVENT     = 8'hF0;
   localparam int          ADDR_LSB      = 2;
   localparam int          ADDR_W        = 10;

   // =====================================================================
   // option_config fields
   localparam int OPT_PULLUP_DIS = 7;
   localparam int OPT_INT_EDGE   = 6;
   localparam int OPT_CLK_SRC    = 5;
   localparam int OPT_SRC_EDGE   = 4;
   localparam int OPT_PS_ASSIGN  = 3;
   localparam int OPT_PS_MSB     = 2;
   localparam logic [7:0] OPT_RESET = 8'hFF;

   // =====================================================================
   // interrupt_control fields
   localparam int IC_GIE   = 7;
   localparam int IC_EEWRITE_DONE_IRQ_ENABLE  = 6;
   localparam int IC_TOIE  = 5;
   localparam int IC_EXIE  = 4;
   localparam int IC_PCIE  = 3;
   localparam int IC_TOF   = 2;
   localparam int IC_EXF   = 1;
   localparam int IC_PCF   = 0;
   localparam logic [7:0] IC_RESET = 8'h00;

   localparam int          PC_W        = 13;
   localparam logic [12:0] PC_RESET    = 13'h0000;
   localparam logic [4:0]  LATCH_RESET = 5'h00;
   localparam logic [7:0]  PS_RESET    = 8'h00;

   // events arriving from the surrounding core and peripherals
   typedef struct packed {
      logic timer_overflow;
      logic eewrite_done;
      logic timer_ext_clock_pin;
      logic ext_interrupt_pin;
      logic [3:0] port_upper_nibble_pins;
   } oipr_event_in_t;

   // controls driven toward timer, watchdog, port and the core's interrupt request input
   typedef struct packed {
      logic       timer_tick;
      logic       watchdog_tick;
      logic [7:0] portb_pullup_en;
      logic       irq_request;
   } oipr_ctrl_out_t;

endpackage

// [rtl/oipr_regs.sv]
// oipr_regs: option, interrupt control and program counter register bank.
// assumes inputs synchronous to pclk; instruction_clock is a one-cycle tick;
// the core fetches from pc_out and pulses pc_advance once per instruction.
//
// Operation
// R1 - clock source bit set counts external pin edges, clear counts cycles
// R2 - source edge bit set counts falling pin edges, clear rising
// R3 - prescaler on watchdog leaves the timer at one to one
// R4 - rate divides timer by 2^(n+1), watchdog by 2^n
// R5 - interrupt edge bit set triggers on rising, clear on falling
// R6 - pull-up disable clear enables port B pull-ups except on outputs
// R7 - flags set on their condition regardless of any enable
// R8 - global enable passes unmasked interrupts, clear blocks all
// R9 - write-complete enable gates that interrupt source
// R10 - timer overflow enable gates the timer interrupt
// R11 - external pin enable gates the pin interrupt
// R12 - port change enable gates the upper nibble change interrupt
// R13 - timer overflow flag sticks until software clears it
// R14 - external pin flag sticks until software writes it clear
// R15 - port change flag sets on upper nibble change, software clears
// R16 - interrupt control appears at two addresses sharing one storage
// R17 - program counter is thirteen bits
// R18 - low byte of program counter is readable and writable
// R19 - upper counter bits only load from the high latch register
`timescale 1ns/1ps
`default_nettype none
module oipr_regs
   import oipr_pkg::*;
#(
   parameter int PS_W = 8
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [oipr_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]              pwdata,
   input  wire logic [3:0]               pstrb,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     instruction_clock,
   input  wire logic                     pc_advance,
   input  wire logic [7:0]               portb_dir_input,
   input  wire oipr_pkg::oipr_event_in_t ev,
   output oipr_pkg::oipr_ctrl_out_t      ctrl,
   output logic      [oipr_pkg::PC_W-1:0] pc_out
);
   import oipr_pkg::*;

   // the widest tap is eight stages, so a shorter counter cannot serve it
   generate
      if (PS_W < 8) begin : g_bad_ps_w
         $error("prescaler must be at least 8 bits");
      end
   endgenerate

   // =====================================================================
   // apb decode
   logic [7:0]  opt_q, ic_q, ic_d;
   logic [4:0]  latch_q;
   logic [12:0] pc_q, pc_d;
   logic [PS_W-1:0] ps_q, ps_d;
   logic [7:0]  rdat_q;
   logic        ext_q, tck_q;
   logic [3:0]  nib_q;

   wire [7:0] idx      = paddr[ADDR_W-1:ADDR_LSB];
   wire       acc      = psel & penable;
   wire       sel_ic   = (idx == IDX_INTCTL_B0) | (idx == IDX_INTCTL_B1); // see R16
   wire       sel_opt  = idx == IDX_OPTION;
   wire       sel_pcl  = idx == IDX_PC_LOW;
   wire       sel_lat  = idx == IDX_PC_LATCH;
   wire       mapped   = sel_ic | sel_opt | sel_pcl | sel_lat;
   wire       wr_ok    = acc & pwrite & pstrb[0];
   wire       wr_ic    = wr_ok & sel_ic;
   wire       wr_opt   = wr_ok & sel_opt;
   wire       wr_pcl   = wr_ok & sel_pcl;
   wire       wr_lat   = wr_ok & sel_lat;
   wire [7:0] wbyte    = pwdata[7:0];

   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   // reads show live flags; pc low byte is the running counter
   wire [7:0] rmux = sel_ic  ? ic_q :
                     sel_opt ? opt_q :
                     sel_pcl ? pc_q[7:0] : // see R18
                     sel_lat ? {3'b000, latch_q} : 8'h00;

   // =====================================================================
   // option fields
   wire       ext_src   = opt_q[OPT_CLK_SRC];
   wire       fall_edge = opt_q[OPT_SRC_EDGE];
   wire       ps_wdt    = opt_q[OPT_PS_ASSIGN];
   wire [2:0] ps_rate   = opt_q[OPT_PS_MSB -: 3];

   // timer source: pin edge or instruction cycle
   wire t_rise   = ev.timer_ext_clock_pin & ~tck_q;
   wire t_fall   = ~ev.timer_ext_clock_pin & tck_q;
   wire pin_edge = fall_edge ? t_fall : t_rise;                  // see R2
   wire src_tick = ext_src ? pin_edge : instruction_clock;       // see R1

   // prescaler input is the timer source, or the watchdog's own tick
   wire ps_in    = ps_wdt ? instruction_clock : src_tick;
   // tap n+1 for timer, tap n for watchdog; tap 0 means no division
   wire [3:0] tap = ps_wdt ? {1'b0, ps_rate} : {1'b0, ps_rate} + 4'h1; // see R4
   assign ps_d = ps_in ? ps_q + 1'b1 : ps_q;
   // output fires when all bits below the tap wrap to zero on an input tick
   wire [PS_W:0] low_mask = ({{PS_W{1'b0}}, 1'b1} << tap) - 1'b1;
   wire ps_out = ps_in & (tap == 4'h0 ? 1'b1 : ((ps_d & low_mask[PS_W-1:0]) == '0));

   assign ctrl.timer_tick    = ps_wdt ? src_tick : ps_out;      // see R3
   assign ctrl.watchdog_tick = ps_wdt ? ps_out : instruction_clock;

   // pull-ups on when bit clear and pin is an input
   generate
      for (genvar i = 0; i < 8; i++) begin : g_pu
         assign ctrl.portb_pullup_en[i] = ~opt_q[OPT_PULLUP_DIS] & portb_dir_input[i]; // see R6
      end
   endgenerate

   // =====================================================================
   // interrupt flags and request
   wire ext_ev = opt_q[OPT_INT_EDGE] ? (ev.ext_interrupt_pin & ~ext_q)
                                     : (~ev.ext_interrupt_pin & ext_q); // see R5
   wire nib_ev = |(ev.port_upper_nibble_pins ^ nib_q);

   // set wins over a software clear in the same cycle
   always_comb begin
      ic_d = wr_ic ? wbyte : ic_q;
      ic_d[IC_TOF] = ic_d[IC_TOF] | ev.timer_overflow;           // see R7 see R13
      ic_d[IC_EXF] = ic_d[IC_EXF] | ext_ev;                      // see R14
      ic_d[IC_PCF] = ic_d[IC_PCF] | nib_ev;                      // see R15
   end

   // write-complete status lives outside; its enable gates the live event
   assign ctrl.irq_request = ic_q[IC_GIE] & (                    // see R8
        (ic_q[IC_EEWRITE_DONE_IRQ_ENABLE] & ev.eewrite_done)                        // see R9
      | (ic_q[IC_TOIE] & ic_q[IC_TOF])                           // see R10
      | (ic_q[IC_EXIE] & ic_q[IC_EXF])                           // see R11
      | (ic_q[IC_PCIE] & ic_q[IC_PCF]));                         // see R12

   // =====================================================================
   // program counter
   // a pcl write loads the whole counter: high bits come only from the latch
   always_comb begin
      pc_d = pc_q;
      if (wr_pcl) begin
         pc_d = {latch_q, wbyte};                                // see R19
      end else if (pc_advance) begin
         pc_d = pc_q + 13'h0001;                                 // see R17
      end
   end
   assign pc_out = pc_q;
   assign prdata = {24'h000000, rdat_q};

   // =====================================================================
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_q   <= OPT_RESET;
         ic_q    <= IC_RESET;
         latch_q <= LATCH_RESET;
         pc_q    <= PC_RESET;
         ps_q    <= '0;
         rdat_q  <= 8'h00;
         ext_q   <= 1'b0;
         tck_q   <= 1'b0;
         nib_q   <= 4'h0;
      end else begin
         if (wr_opt) opt_q <= wbyte;
         if (wr_lat) latch_q <= wbyte[4:0];
         ic_q   <= ic_d;
         pc_q   <= pc_d;
         ps_q   <= ps_d;
         rdat_q <= (psel & ~penable & ~pwrite) ? rmux : rdat_q;
         ext_q  <= ev.ext_interrupt_pin;
         tck_q  <= ev.timer_ext_clock_pin;
         nib_q  <= ev.port_upper_nibble_pins;
      end
   end

endmodule
`default_nettype wire

// [sim/oipr_regs_sva.sv]
// oipr_regs_sva: port level checks of the register bank.
// assumes it is bound onto oipr_regs, one pclk domain.
`timescale 1ns/1ps
`default_nettype none
module oipr_regs_sva
   import oipr_pkg::*;
(
   input wire logic                      pclk,
   input wire logic                      presetn,
   input wire logic                      psel,
   input wire logic                      penable,
   input wire logic                      pwrite,
   input wire logic [oipr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0]               pwdata,
   input wire logic [3:0]                pstrb,
   input wire logic [31:0]               prdata,
   input wire logic                      pready,
   input wire logic                      pslverr,
   input wire logic                      pc_advance,
   input wire logic [7:0]                portb_dir_input,
   input wire oipr_pkg::oipr_ctrl_out_t  ctrl,
   input wire logic [oipr_pkg::PC_W-1:0] pc_out
);
   // =====
   // assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire pcw = psel && penable && pwrite && pstrb[0] && paddr == {IDX_PC_LOW, 2'b00};
   wire pcr = psel && penable && !pwrite && paddr == {IDX_PC_LOW, 2'b00};
   pready_high_a: assert property (pready) else $error("pready low");
   rd_upper_a: assert property (prdata[31:8] == 24'h0) else $error("upper data");
   err_access_a: assert property (pslverr |-> psel && penable) else $error("slverr");
   pullup_out_a: assert property ((ctrl.portb_pullup_en & ~portb_dir_input) == 8'h00)
      else $error("pull-up on output");
   pc_write_a: assert property (pcw |=> pc_out[7:0] == $past(pwdata[7:0]))
      else $error("pc low write");
   pc_incr_a: assert property (pc_advance && !pcw |=> pc_out == $past(pc_out) + 13'h0001)
      else $error("pc increment");
   pc_hold_a: assert property (!pc_advance && !pcw |=> $stable(pc_out))
      else $error("pc moved");
   pc_read_a: assert property (pcr |-> prdata[7:0] == $past(pc_out[7:0]))
      else $error("pc low read");
   cover property (pcw);
   cover property (pc_advance && !pcw);
   cover property (pslverr);
endmodule
`default_nettype wire

// [sim/oipr_regs_test.sv]
// oipr_regs_test: bus level tests of the register bank.
// assumes the checker file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
   $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, e); end end
module oipr_regs_test;
   import oipr_pkg::*;
   logic           pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic           pready, pslverr, se, ic = 0, adv = 0;
   logic [9:0]     paddr = '0;
   logic [31:0]    pwdata = '0, prdata, rd;
   logic [3:0]     pstrb = 4'hF;
   logic [7:0]     dir = 8'h0F;
   logic [12:0]    pc_out;
   oipr_event_in_t ev = '0;
   oipr_ctrl_out_t ctrl;
   int             err_count = 0, tests_run = 0, nt, nw;
   logic [7:0]     opt_tab [5] = '{8'hC0, 8'hC8, 8'hC9, 8'hE8, 8'hF8};
   int             tt [5] = '{8, 16, 16, 16, 16};
   int             wt [5] = '{16, 16, 8, 16, 16};
   always #5 pclk = ~pclk;
   oipr_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .instruction_clock(ic), .pc_advance(adv),
      .portb_dir_input(dir), .ev, .ctrl, .pc_out);
   // =====
   // bus and stimulus tasks
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask
   // ticks are counted after the edge, so a one-cycle pulse counts once
   task automatic ticks(input int n, input logic ext);
      nt = 0;
      nw = 0;
      for (int c = 0; c < 4 * n + 8; c++) begin
         @(posedge pclk);
         nt += ctrl.timer_tick;
         nw += ctrl.watchdog_tick;
         ic <= (c % 4 == 0) && c < 4 * n;
         ev.timer_ext_clock_pin <= ext && (c % 4 < 2) && c < 4 * n;
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #50us;
      err_count++;
      complete_run();
   end
   // =====
   // tests
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      bus(0, IDX_OPTION, 0);
      `CHK(rd, 32'h000000FF)
      `CHK(ctrl.portb_pullup_en, 8'h00)
      bus(0, IDX_INTCTL_B1, 0);
      `CHK(rd, 32'h0)
      bus(1, IDX_OPTION, 8'h7F);
      `CHK(ctrl.portb_pullup_en, 8'h0F)
      @(posedge pclk) ev <= 8'h91;
      @(posedge pclk) ev <= 8'h51;
      bus(0, IDX_INTCTL_B0, 0);
      `CHK(rd, 32'h07)
      `CHK(ctrl.irq_request, 1'b0)
      bus(1, IDX_INTCTL_B0, 8'h87);
      `CHK(ctrl.irq_request, 1'b0)
      for (int i = 3; i < 7; i++) begin
         bus(1, IDX_INTCTL_B0, 8'h87 | (8'h01 << i));
         `CHK(ctrl.irq_request, 1'b1)
         bus(1, IDX_INTCTL_B1, 8'h07 | (8'h01 << i));
         `CHK(ctrl.irq_request, 1'b0)
      end
      bus(1, IDX_INTCTL_B1, 8'h00);
      bus(0, IDX_INTCTL_B0, 0);
      `CHK(rd, 32'h0)
      bus(1, IDX_OPTION, 8'h3F);
      @(posedge pclk) ev <= 8'h00;
      bus(0, IDX_INTCTL_B0, 0);
      `CHK(rd, 32'h03)
      bus(1, IDX_INTCTL_B0, 8'h00);
      @(posedge pclk) ev <= 8'h10;
      bus(0, IDX_INTCTL_B0, 0);
      `CHK(rd, 32'h0)
      bus(1, IDX_PC_LATCH, 8'h15);
      bus(1, IDX_PC_LOW, 8'h34);
      `CHK(pc_out, 13'h1534)
      @(posedge pclk) adv <= 1'b1;
      @(posedge pclk) adv <= 1'b0;
      bus(1, IDX_PC_LATCH, 8'h0A);
      `CHK(pc_out, 13'h1535)
      bus(0, IDX_PC_LOW, 0);
      `CHK(rd, 32'h35)
      bus(0, 8'h40, 0);
      `CHK({se, rd}, {1'b1, 32'h0})
      for (int i = 0; i < 5; i++) begin
         bus(1, IDX_OPTION, opt_tab[i]);
         ticks(16, opt_tab[i][5]);
         `CHK(nt, tt[i])
         if (opt_tab[i][3]) `CHK(nw, wt[i])
      end
      complete_run();
   end
endmodule
bind oipr_regs oipr_regs_sva i_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pready, .pslverr, .pc_advance, .portb_dir_input, .ctrl, .pc_out);
`default_nettype wire
